/* qprt_duration_timer.sv */
/*
 * Microsecond duration timer for the receive queue.
 * Assumes rx_pending comes from logic on the same clock.
 */
`timescale 1ns/1ps
module qprt_duration_timer
    import qprt_pkg::*;
#(
    parameter int UNIT_CYCLES = DURATION_UNIT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rx_pending,
    input wire logic [15:0] limit,
    output logic exceeded
);

    if (UNIT_CYCLES < 1) begin : g_bad_unit
        $error("qprt_duration_timer: UNIT_CYCLES must be at least 1");
    end

    // ==========================================================
    // divider and microsecond counter
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic [16:0] us_cnt;
    logic [16:0] next_us_cnt;
    logic tick;

    always_comb begin
        next_div_cnt = div_cnt;
        next_us_cnt = us_cnt;
        tick = 1'b0;
        if (!rx_pending) begin
            next_div_cnt = 16'h0000;
            next_us_cnt = 17'h00000;
        end else begin
            if (div_cnt == 16'(UNIT_CYCLES - 1)) begin
                next_div_cnt = 16'h0000;
                tick = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 16'h0001;
            end
            // saturates rather than wrapping so a stuck queue keeps asserting
            if (tick && !us_cnt[16]) begin
                next_us_cnt = us_cnt + 17'h00001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            div_cnt <= 16'h0000;
            us_cnt <= 17'h00000;
        end else begin
            div_cnt <= next_div_cnt;
            us_cnt <= next_us_cnt;
        end
    end

    assign exceeded = rx_pending && (us_cnt > {1'b0, limit});

endmodule : qprt_duration_timer

/* qprt_host_model.sv */
/*
 * Host processor model: register reads and writes as single-cycle pulses.
 * Assumes reg_rvalid answers one cycle after the read pulse.
 */
`timescale 1ns/1ps
module qprt_host_model
    import qprt_pkg::*;
(
    input wire logic clock,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    output qprt_reg_req_t reg_req
);
    initial reg_req = '0;
    // idle bus shows inverted leftovers, never the last value
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clock);
        #1 reg_req = {2'b10, a, 2'h3, d};
        @(posedge clock);
        #1 reg_req = {2'b00, ~a, 2'h0, ~d};
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge clock);
        #1 reg_req = {2'b01, a, 2'h3, 16'h0000};
        @(posedge clock);
        #1 reg_req = {2'b00, ~a, 2'h0, 16'hffff};
        d = reg_rvalid ? reg_rdata : 16'hxxxx;
    endtask : rd
    task automatic set_rx(input logic auto_on, input logic wss);
        logic [15:0] d;
        rd(OFS_RX_QUEUE_DATA_POINTER, d);
        // pointer zeroed before every burst, strapped bit written back
        wr(OFS_RX_QUEUE_DATA_POINTER,
           {1'b0, auto_on, 1'b0, wss, d[POS_BYTE_ORDER_SELECT], 11'h000});
    endtask : set_rx
endmodule : qprt_host_model

/* qprt_pkg.sv */
/*
 * Shared constants and carrier types for the queue pointer and receive
 * threshold register bank.
 * Assumes a 16-bit host register port with byte enables and one 25 MHz clock.
 */
package qprt_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [11:0] OFS_TX_QUEUE_DATA_POINTER = 12'h184;
    localparam logic [11:0] OFS_RX_QUEUE_DATA_POINTER = 12'h186;
    localparam logic [11:0] OFS_RX_DURATION_THRESHOLD = 12'h18c;
    localparam logic [11:0] OFS_RX_BYTE_COUNT_THRESHOLD = 12'h18e;

    // ==========================================================
    // field positions
    localparam int POS_AUTO_ADVANCE = 14;
    localparam int POS_WRITE_SAMPLE_SELECT = 12;
    localparam int POS_BYTE_ORDER_SELECT = 11;
    localparam int POS_RX_STATUS = 13;
    localparam int POS_DURATION_ENABLE = 7;
    localparam int POS_BYTE_COUNT_ENABLE = 6;
    localparam int PTR_FIELD_W = 11;

    // ==========================================================
    // reset values and limits
    localparam logic [10:0] RST_POINTER = 11'h000;
    localparam logic RST_AUTO_ADVANCE = 1'b0;
    localparam logic RST_WRITE_SAMPLE_SELECT = 1'b1;
    localparam logic [15:0] RST_DURATION_LIMIT = 16'h0000;
    localparam logic [15:0] RST_BYTE_LIMIT = 16'h0000;
    localparam logic [15:0] MAX_DURATION_LIMIT = 16'hcfff;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int DURATION_UNIT_NS = 1000;
    localparam int DURATION_UNIT_CYCLES = DURATION_UNIT_NS / CLK_PERIOD_NS;

    // ==========================================================
    // carriers
    typedef enum logic [1:0] {
        QPRT_SIZE_BYTE = 2'h0,
        QPRT_SIZE_WORD = 2'h1,
        QPRT_SIZE_DWORD = 2'h2
    } qprt_size_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } qprt_reg_req_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] size;
    } qprt_data_acc_t;

    typedef struct packed {
        logic tx_enqueue;
        logic [10:0] tx_next_free;
        logic [7:0] rx_frame_count;
        logic [15:0] rx_byte_count;
    } qprt_queue_state_t;

endpackage : qprt_pkg

/* qprt_regs.sv */
/*
 * Queue data pointers, write sample select, strapped byte order and the
 * receive duration / byte count thresholds with the receive status flag.
 * Assumes a 16-bit host register port on the device clock, data-register
 * access pulses from the host interface and queue state from the queue
 * manager, all on the same clock; only the strap pin is asynchronous.
 */
// Behaviour
// - tx pointer auto advances on each data write when its auto bit is set.
// - advance equals access size: one, two or four.
// - tx auto bit clear: data accesses leave tx pointer alone.
// - tx pointer resets to zero, reloads to next free slot on enqueue.
// - rx pointer auto advances on each data read when its auto bit is set.
// - rx auto bit clear: data reads leave rx pointer alone.
// - write sample select bit, reset one, chooses the strobe sample point.
// - byte order bit reports strap captured at reset release.
// - duration threshold is 16 bits in microseconds, at most 0xcfff.
// - duration enable set: status set when queue age exceeds threshold.
// - byte count enable set: status set when queued bytes exceed threshold.
// - status bit stays set on read, clears only on write of one.
// - interrupt output active only while status and enable both set.
`timescale 1ns/1ps
module qprt_regs
    import qprt_pkg::*;
#(
    parameter int PTR_W = PTR_FIELD_W,
    parameter int UNIT_CYCLES = DURATION_UNIT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire qprt_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire qprt_data_acc_t data_acc,
    input wire qprt_queue_state_t queue_state,
    input wire logic [15:0] receive_queue_control,
    input wire logic rx_status_clear,
    input wire logic rx_irq_enable,
    input wire logic byte_order_strap,
    output logic [10:0] tx_pointer_field,
    output logic [10:0] rx_pointer_field,
    output logic write_sample_select,
    output logic byte_order_select,
    output logic rx_status,
    output logic irq_n
);

    if (PTR_W != PTR_FIELD_W) begin : g_bad_ptr_w
        $error("qprt_regs: pointer width must match the 11-bit field");
    end
    if (UNIT_CYCLES < 1) begin : g_bad_unit
        $error("qprt_regs: UNIT_CYCLES must be at least 1");
    end

    // ==========================================================
    // helpers
    function automatic logic [10:0] step_of(input logic [1:0] size);
        logic [10:0] s;
        s = 11'h000;
        unique case (size)
            QPRT_SIZE_BYTE: s = 11'h001;
            QPRT_SIZE_WORD: s = 11'h002;
            QPRT_SIZE_DWORD: s = 11'h004;
            default: s = 11'h000;
        endcase
        return s;
    endfunction : step_of

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] be);
        logic [15:0] m;
        m = old;
        if (be[0]) begin
            m[7:0] = wd[7:0];
        end
        if (be[1]) begin
            m[15:8] = wd[15:8];
        end
        return m;
    endfunction : merge

    logic hit_tx;
    logic hit_rx;
    logic hit_dur;
    logic hit_byte;
    assign hit_tx = reg_req.addr == OFS_TX_QUEUE_DATA_POINTER;
    assign hit_rx = reg_req.addr == OFS_RX_QUEUE_DATA_POINTER;
    assign hit_dur = reg_req.addr == OFS_RX_DURATION_THRESHOLD;
    assign hit_byte = reg_req.addr == OFS_RX_BYTE_COUNT_THRESHOLD;

    // ==========================================================
    // transmit pointer register
    logic tx_pointer_auto_advance;
    logic next_tx_auto;
    logic [10:0] next_tx_ptr;
    logic [15:0] tx_img;
    logic [15:0] tx_merged;

    assign tx_img = {1'b0, tx_pointer_auto_advance, 3'h0, tx_pointer_field};
    assign tx_merged = merge(tx_img, reg_req.wdata, reg_req.be);

    always_comb begin
        next_tx_auto = tx_pointer_auto_advance;
        next_tx_ptr = tx_pointer_field;
        if (reg_req.wr && hit_tx) begin
            next_tx_auto = tx_merged[POS_AUTO_ADVANCE];
            next_tx_ptr = tx_merged[10:0];
        end else if (data_acc.wr && tx_pointer_auto_advance) begin
            // 11-bit sum drops the carry, giving the wrap
            next_tx_ptr = tx_pointer_field + step_of(data_acc.size);
        end
        // enqueue wins: the pointer must land on the fresh frame slot
        if (queue_state.tx_enqueue) begin
            next_tx_ptr = queue_state.tx_next_free;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_pointer_auto_advance <= RST_AUTO_ADVANCE;
            tx_pointer_field <= RST_POINTER;
        end else begin
            tx_pointer_auto_advance <= next_tx_auto;
            tx_pointer_field <= next_tx_ptr;
        end
    end

    // ==========================================================
    // receive pointer register
    logic rx_pointer_auto_advance;
    logic next_rx_auto;
    logic next_wss;
    logic [10:0] next_rx_ptr;
    logic [15:0] rx_img;
    logic [15:0] rx_merged;

    assign rx_img = {1'b0, rx_pointer_auto_advance, 1'b0, write_sample_select,
                     byte_order_select, rx_pointer_field};
    assign rx_merged = merge(rx_img, reg_req.wdata, reg_req.be);

    always_comb begin
        next_rx_auto = rx_pointer_auto_advance;
        next_wss = write_sample_select;
        next_rx_ptr = rx_pointer_field;
        if (reg_req.wr && hit_rx) begin
            next_rx_auto = rx_merged[POS_AUTO_ADVANCE];
            next_wss = rx_merged[POS_WRITE_SAMPLE_SELECT];
            next_rx_ptr = rx_merged[10:0];
        end else if (data_acc.rd && rx_pointer_auto_advance) begin
            next_rx_ptr = rx_pointer_field + step_of(data_acc.size);
        end
        // with auto advance clear nothing but a register write moves it
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_pointer_auto_advance <= RST_AUTO_ADVANCE;
            write_sample_select <= RST_WRITE_SAMPLE_SELECT;
            rx_pointer_field <= RST_POINTER;
        end else begin
            rx_pointer_auto_advance <= next_rx_auto;
            write_sample_select <= next_wss;
            rx_pointer_field <= next_rx_ptr;
        end
    end

    // ==========================================================
    // byte order strap
    logic [2:0] strap_sync;
    logic [1:0] strap_fill;
    logic [1:0] next_strap_fill;
    logic strap_taken;
    logic next_strap_taken;
    logic next_byte_order;

    always_comb begin
        next_strap_fill = strap_fill;
        next_strap_taken = strap_taken;
        next_byte_order = byte_order_select;
        // stages must fill first, else the reset zeros would be latched
        if (strap_fill != 2'h3) begin
            next_strap_fill = strap_fill + 2'h1;
        end
        // captured once after release; host writes never touch it
        if (!strap_taken && (strap_fill == 2'h3) && (strap_sync[1] == strap_sync[2])) begin
            next_strap_taken = 1'b1;
            next_byte_order = strap_sync[2];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            strap_sync <= 3'h0;
            strap_fill <= 2'h0;
            strap_taken <= 1'b0;
            byte_order_select <= 1'b0;
        end else begin
            strap_sync <= {strap_sync[1:0], byte_order_strap};
            strap_fill <= next_strap_fill;
            strap_taken <= next_strap_taken;
            byte_order_select <= next_byte_order;
        end
    end

    // ==========================================================
    // thresholds
    logic [15:0] rx_duration_limit;
    logic [15:0] rx_byte_limit;
    logic [15:0] next_dur;
    logic [15:0] next_byte;
    logic [15:0] dur_written;

    assign dur_written = merge(rx_duration_limit, reg_req.wdata, reg_req.be);

    always_comb begin
        next_dur = rx_duration_limit;
        next_byte = rx_byte_limit;
        if (reg_req.wr && hit_dur) begin
            // clamp rather than refuse, so a bad write still lands near intent
            next_dur = (dur_written > MAX_DURATION_LIMIT) ? MAX_DURATION_LIMIT
                                                          : dur_written;
        end
        if (reg_req.wr && hit_byte) begin
            next_byte = merge(rx_byte_limit, reg_req.wdata, reg_req.be);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_duration_limit <= RST_DURATION_LIMIT;
            rx_byte_limit <= RST_BYTE_LIMIT;
        end else begin
            rx_duration_limit <= next_dur;
            rx_byte_limit <= next_byte;
        end
    end

    // ==========================================================
    // receive status and interrupt
    logic dur_exceeded;
    logic set_event;
    logic next_rx_status;

    qprt_duration_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .rx_pending(queue_state.rx_frame_count != 8'h00),
        .limit(rx_duration_limit),
        .exceeded(dur_exceeded)
    );

    assign set_event = (receive_queue_control[POS_DURATION_ENABLE] && dur_exceeded)
        || (receive_queue_control[POS_BYTE_COUNT_ENABLE]
            && (queue_state.rx_byte_count > rx_byte_limit));

    always_comb begin
        next_rx_status = rx_status;
        if (rx_status_clear) begin
            next_rx_status = 1'b0;
        end
        // a fresh event in the clearing cycle must not be lost
        if (set_event) begin
            next_rx_status = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_status <= 1'b0;
        end else begin
            rx_status <= next_rx_status;
        end
    end

    assign irq_n = !(rx_status && rx_irq_enable);

    // ==========================================================
    // read port
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = 16'h0000;
        if (reg_req.rd) begin
            if (hit_tx) begin
                next_rdata = tx_img;
            end else if (hit_rx) begin
                // pointer field is write-only and reads as zero
                next_rdata = {1'b0, rx_pointer_auto_advance, 1'b0, write_sample_select,
                              byte_order_select, 11'h000};
            end else if (hit_dur) begin
                next_rdata = rx_duration_limit;
            end else if (hit_byte) begin
                next_rdata = rx_byte_limit;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            reg_rvalid <= reg_req.rd;
        end
    end

endmodule : qprt_regs

/* qprt_regs_properties.sv */
/*
 * Port-level properties of the queue pointer and receive threshold bank.
 * Assumes one clock and the synchronous active-low reset of qprt_regs.
 */
`timescale 1ns/1ps
module qprt_regs_properties
    import qprt_pkg::*;
#(
    parameter int PTR_W = PTR_FIELD_W,
    parameter int UNIT_CYCLES = DURATION_UNIT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire qprt_reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire qprt_data_acc_t data_acc,
    input wire qprt_queue_state_t queue_state,
    input wire logic [15:0] receive_queue_control,
    input wire logic rx_status_clear,
    input wire logic rx_irq_enable,
    input wire logic [10:0] tx_pointer_field,
    input wire logic [10:0] rx_pointer_field,
    input wire logic write_sample_select,
    input wire logic rx_status,
    input wire logic irq_n
);
    // ==========================================================
    // shadow of host-written control, pre-edge like the design
    logic tx_auto;
    logic rx_auto;
    logic [15:0] byte_lim;
    logic tx_wr;
    logic rx_wr;
    logic [10:0] tx_exp;
    logic [10:0] rx_exp;
    assign tx_wr = reg_req.wr && reg_req.addr == OFS_TX_QUEUE_DATA_POINTER;
    assign rx_wr = reg_req.wr && reg_req.addr == OFS_RX_QUEUE_DATA_POINTER;
    assign tx_exp = tx_pointer_field + (11'h1 << data_acc.size);
    assign rx_exp = rx_pointer_field + (11'h1 << data_acc.size);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_auto <= 1'b0;
            rx_auto <= 1'b0;
            byte_lim <= RST_BYTE_LIMIT;
        end else begin
            if (tx_wr && reg_req.be[1]) tx_auto <= reg_req.wdata[POS_AUTO_ADVANCE];
            if (rx_wr && reg_req.be[1]) rx_auto <= reg_req.wdata[POS_AUTO_ADVANCE];
            if (reg_req.wr && reg_req.addr == OFS_RX_BYTE_COUNT_THRESHOLD) begin
                if (reg_req.be[0]) byte_lim[7:0] <= reg_req.wdata[7:0];
                if (reg_req.be[1]) byte_lim[15:8] <= reg_req.wdata[15:8];
            end
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_reset;
        $rose(rst_n) |-> write_sample_select && tx_pointer_field == RST_POINTER && !rx_status;
    endproperty
    property p_tx_adv;
        data_acc.wr && tx_auto && data_acc.size != 2'h3 && !tx_wr && !queue_state.tx_enqueue
            |=> tx_pointer_field == $past(tx_exp);
    endproperty
    property p_tx_hold;
        data_acc.wr && !tx_auto && !tx_wr && !queue_state.tx_enqueue |=> $stable(tx_pointer_field);
    endproperty
    property p_enq;
        queue_state.tx_enqueue |=> tx_pointer_field == $past(queue_state.tx_next_free);
    endproperty
    property p_rx_adv;
        data_acc.rd && rx_auto && data_acc.size != 2'h3 && !rx_wr
            |=> rx_pointer_field == $past(rx_exp);
    endproperty
    property p_rx_hold;
        data_acc.rd && !rx_auto && !rx_wr |=> $stable(rx_pointer_field);
    endproperty
    property p_sticky;
        rx_status && !rx_status_clear |=> rx_status;
    endproperty
    property p_bytes;
        receive_queue_control[POS_BYTE_COUNT_ENABLE] && queue_state.rx_byte_count > byte_lim
            |=> rx_status;
    endproperty
    property p_irq;
        irq_n == !(rx_status && rx_irq_enable);
    endproperty
    property p_rvalid;
        reg_req.rd |=> reg_rvalid;
    endproperty
    property p_quiet;
        !$past(reg_req.rd) |-> !reg_rvalid && reg_rdata == 16'h0000;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset state");
    a_tx_adv: assert property (p_tx_adv) else $error("tx advance wrong");
    a_tx_hold: assert property (p_tx_hold) else $error("tx pointer moved");
    a_enq: assert property (p_enq) else $error("tx reload wrong");
    a_rx_adv: assert property (p_rx_adv) else $error("rx advance wrong");
    a_rx_hold: assert property (p_rx_hold) else $error("rx pointer moved");
    a_sticky: assert property (p_sticky) else $error("status dropped");
    a_bytes: assert property (p_bytes) else $error("byte status missing");
    a_irq: assert property (p_irq) else $error("irq level wrong");
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    a_quiet: assert property (p_quiet) else $error("stray read data");
    c_tx: cover property (data_acc.wr && tx_auto);
    c_rx: cover property (data_acc.rd && rx_auto);
    c_status: cover property ($rose(rx_status));
endmodule : qprt_regs_properties

bind qprt_regs qprt_regs_properties #(.PTR_W(PTR_W), .UNIT_CYCLES(UNIT_CYCLES))
    u_qprt_regs_properties (.clock, .rst_n, .reg_req, .reg_rdata, .reg_rvalid, .data_acc,
    .queue_state, .receive_queue_control, .rx_status_clear, .rx_irq_enable, .tx_pointer_field,
    .rx_pointer_field, .write_sample_select, .rx_status, .irq_n);

/* tb_top.sv */
/*
 * Self-checking bench for qprt_regs with a host model on the register port.
 * Assumes the microsecond is shortened to two clocks.
 */
`timescale 1ns/1ps
module tb_top
    import qprt_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    qprt_reg_req_t reg_req;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    qprt_data_acc_t data_acc = '0;
    qprt_queue_state_t queue_state = '0;
    logic [15:0] ctrl = 16'h0000;
    logic clr = 1'b0;
    logic irq_en = 1'b0;
    logic strap = 1'b1;
    logic [10:0] tx_ptr;
    logic [10:0] rx_ptr;
    logic wss;
    logic bo;
    logic status;
    logic irq_n;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    logic [15:0] v;
    logic [15:0] lim;
    logic [10:0] p;
    logic [10:0] exp_ptr;

    always #20 clock = ~clock;

    qprt_host_model u_qprt_host_model (.clock(clock), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_req(reg_req));
    qprt_regs #(.UNIT_CYCLES(2)) u_qprt_regs (.clock(clock), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .data_acc(data_acc),
        .queue_state(queue_state), .receive_queue_control(ctrl), .rx_status_clear(clr),
        .rx_irq_enable(irq_en), .byte_order_strap(strap), .tx_pointer_field(tx_ptr),
        .rx_pointer_field(rx_ptr), .write_sample_select(wss), .byte_order_select(bo),
        .rx_status(status), .irq_n(irq_n));

    // ==========================================================
    // helpers
    function automatic logic [10:0] adv(logic [10:0] q, logic [1:0] s);
        return (s == 2'h3) ? q : q + (11'h1 << s);
    endfunction : adv
    task automatic chk(string what, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    task automatic acc(logic w, logic [1:0] s);
        @(posedge clock);
        #1 data_acc = {w, ~w, s};
        @(posedge clock);
        #1 data_acc = '0;
    endtask : acc
    task automatic walk(logic tx, logic auto_on, logic [10:0] start);
        logic [1:0] s;
        exp_ptr = start;
        repeat (12) begin
            s = 2'($urandom_range(3));
            acc(tx, s);
            if (auto_on) exp_ptr = adv(exp_ptr, s);
            chk("pointer", 16'(exp_ptr), 16'(tx ? tx_ptr : rx_ptr));
        end
    endtask : walk
    task automatic reg_chk(logic [11:0] a, logic [15:0] e);
        u_qprt_host_model.rd(a, v);
        chk("register", e, v);
    endtask : reg_chk

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end

    // ==========================================================
    // scenarios
    initial begin
        void'($urandom(32'h60153d05));
        repeat (16) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (5) @(posedge clock);
        #1 chk("byte order", 16'h0001, 16'(bo));
        reg_chk(OFS_TX_QUEUE_DATA_POINTER, 16'h0000);
        reg_chk(OFS_RX_QUEUE_DATA_POINTER, 16'h1800);
        reg_chk(OFS_RX_DURATION_THRESHOLD, 16'h0000);
        reg_chk(OFS_RX_BYTE_COUNT_THRESHOLD, 16'h0000);
        reg_chk(12'h188, 16'h0000);
        u_qprt_host_model.wr(OFS_TX_QUEUE_DATA_POINTER, 16'h47fd);
        walk(1'b1, 1'b1, 11'h7fd);
        reg_chk(OFS_TX_QUEUE_DATA_POINTER, 16'h4000 | 16'(exp_ptr));
        p = 11'($urandom);
        u_qprt_host_model.wr(OFS_TX_QUEUE_DATA_POINTER, 16'(p));
        walk(1'b1, 1'b0, p);
        p = 11'($urandom);
        @(posedge clock);
        #1 queue_state.tx_enqueue = 1'b1;
        queue_state.tx_next_free = p;
        @(posedge clock);
        #1 queue_state.tx_enqueue = 1'b0;
        chk("reload", 16'(p), 16'(tx_ptr));
        u_qprt_host_model.set_rx(1'b1, 1'b1);
        walk(1'b0, 1'b1, 11'h000);
        u_qprt_host_model.set_rx(1'b0, 1'b0);
        walk(1'b0, 1'b0, 11'h000);
        reg_chk(OFS_RX_QUEUE_DATA_POINTER, 16'h0800);
        chk("sample select", 16'h0000, 16'(wss));
        u_qprt_host_model.wr(OFS_RX_DURATION_THRESHOLD, 16'hffff);
        reg_chk(OFS_RX_DURATION_THRESHOLD, MAX_DURATION_LIMIT);
        u_qprt_host_model.wr(OFS_RX_DURATION_THRESHOLD, 16'h0002);
        irq_en = 1'b1;
        ctrl = 16'h0080;
        queue_state.rx_frame_count = 8'h01;
        n = 0;
        while (status !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1 n++;
        end
        chk("duration time", 16'h0001, 16'(n >= 5 && n <= 10));
        chk("irq on", 16'h0000, 16'(irq_n));
        irq_en = 1'b0;
        #1 chk("irq masked", 16'h0001, 16'(irq_n));
        queue_state.rx_frame_count = 8'h00;
        ctrl = 16'h0000;
        reg_chk(OFS_RX_DURATION_THRESHOLD, 16'h0002);
        chk("sticky", 16'h0001, 16'(status));
        @(posedge clock);
        #1 clr = 1'b1;
        @(posedge clock);
        #1 clr = 1'b0;
        chk("cleared", 16'h0000, 16'(status));
        lim = 16'($urandom_range(16'hfffe));
        u_qprt_host_model.wr(OFS_RX_BYTE_COUNT_THRESHOLD, lim);
        reg_chk(OFS_RX_BYTE_COUNT_THRESHOLD, lim);
        ctrl = 16'h0040;
        queue_state.rx_byte_count = lim;
        repeat (3) @(posedge clock);
        #1 chk("at limit", 16'h0000, 16'(status));
        queue_state.rx_byte_count = lim + 16'h0001;
        repeat (2) @(posedge clock);
        #1 chk("over limit", 16'h0001, 16'(status));
        final_report();
    end
endmodule : tb_top
